// ===== rtl/pm_defs.svh
// Register offsets, field positions, reset values and response codes of the power-mode controller.
// Assumes inclusion by its bare name from the package or module that needs it.
`ifndef PM_DEFS_SVH
`define PM_DEFS_SVH
`define PM_OFS_CTRL 4'h0
`define PM_OFS_DIV 4'h4
`define PM_OFS_STAT 4'h8
`define PM_OFS_RTC 4'hc
`define PM_CTRL_W 6
`define PM_FLAG_W 4
`define PM_FLAG_LSB 0
`define PM_STATE_LSB 8
`define PM_DIV_RESET 8'h00
`define PM_RESP_OKAY 2'b00
`define PM_RESP_SLVERR 2'b10
`endif

// ===== rtl/pm_pkg.sv
// Types shared by the power-mode controller: states, control word and sticky flags.
// Assumes pm_defs.svh sits on the include path.
`include "pm_defs.svh"
package pm_pkg;
    // Operating state of the CPU clock domain.
    typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_PDOWN, ST_WAKE} pm_state_t;
    // Control word; idle_req sits in bit 0.
    typedef struct packed {
        logic monitor_en;
        logic watch_en;
        logic sub_en;
        logic slow_en;
        logic pdown_req;
        logic idle_req;
    } ctrl_t;
    // Sticky cause flags; woke_irq sits in bit 0.
    typedef struct packed {
        logic wdt_reset;
        logic lv_reset;
        logic woke_wdt;
        logic woke_irq;
    } flags_t;
endpackage : pm_pkg

// ===== rtl/mcu_power_mode_control.sv
// Power-mode controller: idle, power-down, slow, sub, RTC, watch and monitor modes behind AXI4-Lite.
// Assumes irq_pending comes from the interrupt controller on sys_clk; every other event input is
// asynchronous and is synchronised here. Clock gating cells downstream use the enables driven here.
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "pm_defs.svh"
module mcu_power_mode_control
    import pm_pkg::*;
#(
    parameter int WAKE_SRCS = 10
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq_pending,
    input wire logic [WAKE_SRCS-1:0] wake_src,
    input wire logic watchdog_counter_ovf,
    input wire logic low_voltage,
    input wire logic lso_clk,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic clk_src_lso,
    output logic retain_hold,
    output logic rtc_clk_en,
    output logic wake_irq_service,
    output logic sys_reset_req
);
    // Two-stage synchronisers for everything arriving from pins or other oscillators.
    logic [WAKE_SRCS+2:0] sync1_q;
    logic [WAKE_SRCS+2:0] sync2_q;
    logic wdt_prev_q;
    logic lso_prev_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            wdt_prev_q <= 1'b0;
            lso_prev_q <= 1'b0;
        end else begin
            sync1_q <= {lso_clk, low_voltage, watchdog_counter_ovf, wake_src};
            sync2_q <= sync1_q;
            wdt_prev_q <= sync2_q[WAKE_SRCS];
            lso_prev_q <= sync2_q[WAKE_SRCS+2];
        end
    end

    // Event decode on the synchronised copies only.
    wire any_wake = |sync2_q[WAKE_SRCS-1:0];
    wire wdt_evt = sync2_q[WAKE_SRCS] && !wdt_prev_q;
    wire low_v = sync2_q[WAKE_SRCS+1];
    wire lso_rise = sync2_q[WAKE_SRCS+2] && !lso_prev_q;

    // Register state.
    ctrl_t ctrl_q;
    logic [7:0] div_q;
    flags_t flags_q;
    logic [31:0] rtc_q;
    pm_state_t state_q;
    pm_state_t state_d;
    logic woke_by_irq_q;

    // Write channel: address and data are taken in either order, answered once both are in.
    logic aw_got_q;
    logic w_got_q;
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
    wire wr_ctrl = wr_fire && (awaddr_q == `PM_OFS_CTRL);
    wire wr_div = wr_fire && (awaddr_q == `PM_OFS_DIV);
    wire wr_stat = wr_fire && (awaddr_q == `PM_OFS_STAT);
    wire wr_mapped = wr_ctrl || wr_div || wr_stat || (awaddr_q == `PM_OFS_RTC);

    // Byte lanes expand into a bit mask, one lane per iteration.
    logic [31:0] wmask;
    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign wmask[b*8 +: 8] = {8{wstrb_q[b]}};
    end
    wire [31:0] wmerge_ctrl = (32'(ctrl_q) & ~wmask) | (wdata_q & wmask);
    wire [31:0] wmerge_div = (32'(div_q) & ~wmask) | (wdata_q & wmask);
    wire [`PM_FLAG_W-1:0] w1c = wdata_q[`PM_FLAG_LSB +: `PM_FLAG_W] & wmask[`PM_FLAG_LSB +: `PM_FLAG_W];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PM_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_got_q <= 1'b1;
                awaddr_q <= {s_axi_awaddr[3:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `PM_RESP_OKAY : `PM_RESP_SLVERR;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read channel: one read at a time, data registered on the same edge that takes the address.
    wire [31:0] stat_word = (32'(flags_q) << `PM_FLAG_LSB) | (32'(state_q) << `PM_STATE_LSB);
    wire [3:0] raddr = {s_axi_araddr[3:2], 2'b00};
    wire rd_ctrl = raddr == `PM_OFS_CTRL;
    wire rd_div = raddr == `PM_OFS_DIV;
    wire rd_stat = raddr == `PM_OFS_STAT;
    wire rd_rtc = raddr == `PM_OFS_RTC;
    wire [31:0] rd_word = rd_ctrl ? 32'(ctrl_q) :
                          rd_div ? 32'(div_q) :
                          rd_stat ? stat_word :
                          rd_rtc ? rtc_q : 32'h0;
    wire rd_mapped = rd_ctrl || rd_div || rd_stat || rd_rtc;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `PM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_mapped ? `PM_RESP_OKAY : `PM_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Detection of very low supply is always on while running; in power-down only in monitor mode.
    wire lv_armed = (state_q != ST_PDOWN) || ctrl_q.monitor_en;
    wire lv_reset = low_v && lv_armed;
    wire low_power = (state_q == ST_IDLE) || (state_q == ST_PDOWN);
    wire wdt_wake = wdt_evt && low_power && ctrl_q.watch_en;
    wire wdt_reset = wdt_evt && !wdt_wake;
    // Idle wakes on any pending interrupt; power-down only on the wake-capable sources.
    wire irq_wake = ((state_q == ST_IDLE) && irq_pending) ||
                    ((state_q == ST_PDOWN) && any_wake);
    wire any_reset = lv_reset || wdt_reset;

    // Mode sequencing. Resets win over wake-ups so an armed low-supply reset is never lost to a wake-up.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (ctrl_q.pdown_req) begin
                    state_d = ST_PDOWN;
                end else if (ctrl_q.idle_req) begin
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE, ST_PDOWN: begin
                if (irq_wake || wdt_wake) begin
                    state_d = ST_WAKE;
                end
            end
            ST_WAKE: state_d = ST_RUN;
            default: state_d = ST_RUN;
        endcase
        if (any_reset) begin
            state_d = ST_RUN;
        end
    end

    // Leaving a low-power mode or any reset request clears the request bits, so the CPU resumes rather than re-enters.
    wire leave_low = (state_d == ST_WAKE) || any_reset;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_RUN;
            ctrl_q <= '0;
            div_q <= `PM_DIV_RESET;
            woke_by_irq_q <= 1'b0;
        end else begin
            state_q <= state_d;
            woke_by_irq_q <= irq_wake;
            if (wr_ctrl) begin
                ctrl_q <= ctrl_t'(wmerge_ctrl[`PM_CTRL_W-1:0]);
            end
            if (leave_low) begin
                ctrl_q.pdown_req <= 1'b0;
                ctrl_q.idle_req <= 1'b0;
            end
            if (any_reset) begin
                ctrl_q <= '0;
                div_q <= `PM_DIV_RESET;
            end else if (wr_div) begin
                div_q <= wmerge_div[7:0];
            end
        end
    end

    // Sticky cause flags; a new event in the clearing cycle keeps its flag set.
    flags_t flag_set;
    assign flag_set = '{wdt_reset: wdt_reset, lv_reset: lv_reset,
                        woke_wdt: wdt_wake, woke_irq: irq_wake};
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~(wr_stat ? flags_t'(w1c) : flags_t'('0))) | flag_set;
        end
    end

    // Real-time clock counts low-speed oscillator rising edges in every state; reset requests leave it alone.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rtc_q <= 32'h0;
        end else if (lso_rise) begin
            rtc_q <= rtc_q + 32'h1;
        end
    end

    // System clock enable: undivided, divided by div_q+1, or paced by the low-speed oscillator.
    // The low-speed source wins over the divider because it is the deeper saving.
    logic [7:0] div_cnt_q;
    wire div_hit = div_cnt_q == div_q;
    wire sys_tick = ctrl_q.sub_en ? lso_rise :
                    ctrl_q.slow_en ? div_hit : 1'b1;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt_q <= 8'h00;
        end else if (!ctrl_q.slow_en || div_hit) begin
            div_cnt_q <= 8'h00;
        end else begin
            div_cnt_q <= div_cnt_q + 8'h01;
        end
    end

    // Clock enables and hold signals to the rest of the MCU, all registered.
    wire cpu_on = (state_d == ST_RUN) || (state_d == ST_WAKE);
    wire periph_on = state_d != ST_PDOWN;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cpu_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
            clk_src_lso <= 1'b0;
            retain_hold <= 1'b0;
            rtc_clk_en <= 1'b0;
            wake_irq_service <= 1'b0;
            sys_reset_req <= 1'b0;
        end else begin
            cpu_clk_en <= cpu_on && sys_tick;
            periph_clk_en <= periph_on && sys_tick;
            clk_src_lso <= ctrl_q.sub_en;
            retain_hold <= state_d == ST_PDOWN;
            rtc_clk_en <= 1'b1;
            wake_irq_service <= (state_q == ST_WAKE) && woke_by_irq_q;
            sys_reset_req <= any_reset;
        end
    end
endmodule : mcu_power_mode_control

// ===== test/mcu_power_mode_control_props.sv
// Port-level checks for the power-mode controller, one property per behaviour.
// Assumes it is bound to the top module and sees its clock, reset and ports.
`timescale 1ns/100ps
module mcu_power_mode_control_props #(
    parameter int WAKE_SRCS = 10
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [WAKE_SRCS-1:0] wake_src,
    input wire logic low_voltage,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic retain_hold,
    input wire logic rtc_clk_en,
    input wire logic wake_irq_service,
    input wire logic sys_reset_req
);
    // All checks share one clock; reset disables them so stale samples never count.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    property p_rtc_runs; $past(rstn) |-> rtc_clk_en; endproperty
    a_rtc_runs: assert property (p_rtc_runs) else $error("rtc enable dropped");
    property p_pdown_held; retain_hold |-> !cpu_clk_en && !periph_clk_en; endproperty
    a_pdown_held: assert property (p_pdown_held) else $error("clock runs in power-down");
    property p_pdown_wake; retain_hold && (|wake_src) |-> ##[1:8] !retain_hold; endproperty
    a_pdown_wake: assert property (p_pdown_wake) else $error("no wake from power-down");
    property p_lv_reset; $rose(low_voltage) && !retain_hold |-> ##[1:8] sys_reset_req; endproperty
    a_lv_reset: assert property (p_lv_reset) else $error("no reset on low supply");
    property p_svc_pulse; wake_irq_service |=> !wake_irq_service; endproperty
    a_svc_pulse: assert property (p_svc_pulse) else $error("service pulse too long");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response not held");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data not held");
    property p_ar_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_ar_ans: assert property (p_ar_ans) else $error("read answer late");
    property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready; endproperty
    a_b_done: assert property (p_b_done) else $error("write response not retired");
    property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
    a_r_done: assert property (p_r_done) else $error("read response not retired");
endmodule : mcu_power_mode_control_props
bind mcu_power_mode_control mcu_power_mode_control_props #(.WAKE_SRCS(WAKE_SRCS)) u_props (.*);

// ===== test/mcu_power_mode_control_tb_top.sv
// Self-checking bench for the power-mode controller: mode entry, wake-up, clocking and resets.
// Assumes the design, its package and the bound checker are compiled before this file.
`timescale 1ns/100ps
`include "pm_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 600) begin @(posedge sys_clk); n++; end \
    if (n >= 600) tally_and_finish(1); end
module mcu_power_mode_control_tb_top;
    logic sys_clk = 0, rstn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, irq_pending = 0, watchdog_counter_ovf = 0, low_voltage = 0;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 0, rd, r1;
    logic [9:0] wake_src = 0;
    logic [2:0] lso_div = 0;
    wire lso_clk = lso_div[2];
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_clk_en, periph_clk_en;
    wire clk_src_lso, retain_hold, rtc_clk_en, wake_irq_service, sys_reset_req;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    int error_cnt = 0, checks_done = 0, n, cnt;
    mcu_power_mode_control dut (.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_pending,
        .wake_src, .watchdog_counter_ovf, .low_voltage, .lso_clk, .cpu_clk_en, .periph_clk_en, .clk_src_lso,
        .retain_hold, .rtc_clk_en, .wake_irq_service, .sys_reset_req);
    // The slow oscillator is a divided copy of sys_clk, eight cycles a period, well above the sync limit.
    initial forever #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) lso_div <= lso_div + 3'h1;
    task automatic tally_and_finish(input bit hung);
        if (hung) error_cnt++;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    // Each channel is released once taken; bready and rready stand from the request until the answer is seen.
    // Every register offset is mapped, so every answer must carry OKAY.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        if (n >= 50) tally_and_finish(1);
        `CHK(s_axi_bresp, `PM_RESP_OKAY)
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [3:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        if (n >= 50) tally_and_finish(1);
        rd = s_axi_rdata;
        `CHK(s_axi_rresp, `PM_RESP_OKAY)
        s_axi_rready <= 1'b0;
    endtask : rdr
    task automatic count_en(input int len);
        cnt = 0;
        repeat (len) begin
            @(posedge sys_clk);
            cnt += int'(cpu_clk_en === 1'b1);
        end
    endtask : count_en
    task automatic t_idle;
        wr(`PM_OFS_CTRL, 32'h1);
        repeat (4) @(posedge sys_clk);
        `CHK({cpu_clk_en, periph_clk_en}, 2'b01)
        irq_pending <= 1'b1;
        `WAITC(wake_irq_service === 1'b1)
        irq_pending <= 1'b0;
        rdr(`PM_OFS_CTRL);
        `CHK({cpu_clk_en, rd[0]}, 2'b10)
        $display("test idle done");
    endtask : t_idle
    task automatic t_pdown;
        wr(`PM_OFS_STAT, 32'hf);
        wr(`PM_OFS_DIV, 32'h5a);
        for (int i = 0; i < 10; i += 3) begin
            wr(`PM_OFS_CTRL, 32'h2);
            repeat (4) @(posedge sys_clk);
            `CHK({retain_hold, cpu_clk_en, periph_clk_en}, 3'b100)
            rdr(`PM_OFS_RTC);
            r1 = rd;
            repeat (16) @(posedge sys_clk);
            rdr(`PM_OFS_RTC);
            `CHK(rd !== r1, 1'b1)
            `CHK(rtc_clk_en, 1'b1)
            wake_src[i] <= 1'b1;
            `WAITC(retain_hold === 1'b0)
            wake_src <= 10'h000;
        end
        rdr(`PM_OFS_STAT);
        `CHK(rd[0], 1'b1)
        rdr(`PM_OFS_DIV);
        `CHK(rd[7:0], 8'h5a)
        // A write with the low byte lane off must leave the divider setting alone.
        s_axi_wstrb <= 4'he;
        wr(`PM_OFS_DIV, 32'h33);
        s_axi_wstrb <= 4'hf;
        rdr(`PM_OFS_DIV);
        `CHK(rd[7:0], 8'h5a)
        $display("test power-down done");
    endtask : t_pdown
    // A low and the top divider setting (3 and 255): one enable per DIV+1 cycles.
    task automatic t_slow;
        int dv[2] = '{3, 255};
        foreach (dv[i]) begin
            wr(`PM_OFS_DIV, 32'(dv[i]));
            wr(`PM_OFS_CTRL, 32'h4);
            count_en(4 * (dv[i] + 1));
            `CHK(cnt, 4)
        end
        wr(`PM_OFS_CTRL, 32'hc);
        repeat (2) @(posedge sys_clk);
        `CHK(clk_src_lso, 1'b1)
        count_en(64);
        `CHK(cnt, 8)
        rdr(`PM_OFS_RTC);
        r1 = rd;
        repeat (16) @(posedge sys_clk);
        rdr(`PM_OFS_RTC);
        `CHK(rd !== r1, 1'b1)
        wr(`PM_OFS_CTRL, 32'h0);
        $display("test clocking done");
    endtask : t_slow
    task automatic t_watch;
        wr(`PM_OFS_STAT, 32'hf);
        wr(`PM_OFS_CTRL, 32'h12);
        repeat (4) @(posedge sys_clk);
        watchdog_counter_ovf <= 1'b1;
        `WAITC(retain_hold === 1'b0)
        watchdog_counter_ovf <= 1'b0;
        rdr(`PM_OFS_STAT);
        `CHK(rd[3:0], 4'h2)
        repeat (4) @(posedge sys_clk);
        watchdog_counter_ovf <= 1'b1;
        `WAITC(sys_reset_req === 1'b1)
        watchdog_counter_ovf <= 1'b0;
        $display("test watch done");
    endtask : t_watch
    // Low supply in run, then in power-down with detection kept alive.
    task automatic t_lv;
        logic [31:0] lvc[2] = '{32'h0, 32'h22};
        foreach (lvc[i]) begin
            wr(`PM_OFS_STAT, 32'hf);
            wr(`PM_OFS_CTRL, lvc[i]);
            repeat (4) @(posedge sys_clk);
            low_voltage <= 1'b1;
            `WAITC(sys_reset_req === 1'b1)
            low_voltage <= 1'b0;
            repeat (4) @(posedge sys_clk);
            rdr(`PM_OFS_STAT);
            `CHK(rd[2], 1'b1)
        end
        rdr(`PM_OFS_CTRL);
        `CHK(rd[5:0], 6'h00)
        rdr(`PM_OFS_DIV);
        `CHK(rd[7:0], 8'h00)
        $display("test monitor done");
    endtask : t_lv
    initial begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        t_idle;
        t_pdown;
        t_slow;
        t_watch;
        t_lv;
        tally_and_finish(0);
    end
endmodule : mcu_power_mode_control_tb_top
